// *** pmsr_defs.svh ***
// Offsets, field positions, reset values and timing counts of the status bank.
// Assumes inclusion by bare name from the design modules.
`ifndef PMSR_DEFS_SVH
`define PMSR_DEFS_SVH
// ==================================================
// Register offsets
`define PMSR_OFS_CONV12 8'h6D
`define PMSR_OFS_CONV34 8'h6E
`define PMSR_OFS_VMON 8'h72
`define PMSR_OFS_STARTUP 8'h73
`define PMSR_OFS_MISC 8'h74
// ==================================================
// Field positions inside a converter pair register
`define PMSR_BIT_HI_ILIM 7
`define PMSR_BIT_HI_UV 5
`define PMSR_BIT_HI_OV 4
`define PMSR_BIT_LO_ILIM 3
`define PMSR_BIT_LO_UV 1
`define PMSR_BIT_LO_OV 0
// Voltage monitor register
`define PMSR_BIT_MON2_UV 6
`define PMSR_BIT_MON2_OV 5
`define PMSR_BIT_MON1_UV 3
`define PMSR_BIT_MON1_OV 2
`define PMSR_BIT_SUP_UV 1
`define PMSR_BIT_SUP_OV 0
// Startup and misc registers
`define PMSR_BIT_ENABLE 1
`define PMSR_BIT_TWARN 3
`define PMSR_BIT_EXTCLK 1
// ==================================================
// Reset value of every register and of the read data
`define PMSR_RESET_VALUE 8'h00
// Input synchroniser depth
`define PMSR_SYNC_STAGES 3
`endif

// *** pmsr_pkg.sv ***
// Types shared by the status bank modules.
// Assumes pmsr_defs.svh is on the include path.
package pmsr_pkg;
    // ==================================================
    // Conditions of one converter
    typedef struct packed {
        logic current_limit;
        logic undervoltage;
        logic overvoltage;
    } pmsr_conv_t;

    // Condition vector: four current-limit, four undervoltage, four overvoltage
    // flags, then the nine single flags, in the capture order of the bank
    typedef logic [20:0] pmsr_cond_t;
endpackage

// *** pmsr_cond_if.sv ***
// Carries synchronised condition flags from the synchroniser to the bank.
// Assumes both ends run on the same clock.
interface pmsr_cond_if;
    pmsr_pkg::pmsr_cond_t cond;
    modport source (output cond);
    modport sink (input cond);
endinterface

// *** pmsr_sync.sv ***
// Three-stage synchroniser for the asynchronous condition flags.
// Assumes flags come from analog comparators outside the clock domain.
`include "pmsr_defs.svh"
module pmsr_sync #(
    parameter int WIDTH = 21
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] raw_in,
    pmsr_cond_if.source cond_port
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] stable;
    } pmsr_sync_state_t;

    pmsr_sync_state_t state;
    pmsr_sync_state_t next_state;

    // ==================================================
    // Change is accepted only when stages two and three agree
    always_comb begin
        next_state = state;
        next_state.s1 = raw_in;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.stable[i] = state.s3[i];
            end
        end
        if (rst_in) begin
            next_state = '0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        state <= next_state;
    end

    assign cond_port.cond = state.stable;
endmodule

// *** pmsr_status_bank.sv ***
// Read-only status register bank of a multi-phase power management device.
// Assumes a simple register read/write port driven by the serial interface
// logic on the same clock; condition flags arrive asynchronously.
// Summary of operation
// - Current-limit flags at bits 7 and 3
// - Undervoltage flags at bits 5 and 1
// - Overvoltage flags at bits 4 and 0
// - Converters four and three at 0x6E
// - Monitor two: undervoltage bit 6, overvoltage bit 5
// - Monitor one: undervoltage bit 3, overvoltage bit 2
// - Analog supply flags at 0x72 bits 1, 0
// - Enable pin level at 0x73 bit 1
// - Thermal warning at 0x74 bit 3
// - External clock invalid at 0x74 bit 1
// - All registers read-only, reset to zero
// - Converters one and two at 0x6D
`include "pmsr_defs.svh"
module pmsr_status_bank (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] conv_current_limit_in,
    input wire logic [3:0] conv_undervoltage_in,
    input wire logic [3:0] conv_overvoltage_in,
    input wire logic ext_monitor1_undervoltage_flag_in,
    input wire logic ext_monitor1_overvoltage_flag_in,
    input wire logic ext_monitor2_undervoltage_flag_in,
    input wire logic ext_monitor2_overvoltage_flag_in,
    input wire logic analog_supply_undervoltage_flag_in,
    input wire logic analog_supply_overvoltage_flag_in,
    input wire logic enable_pin_in,
    input wire logic thermal_warning_flag_in,
    input wire logic external_clock_invalid_flag_in,
    input wire logic reg_read_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_hit_out
);
    // ==================================================
    // Condition capture
    // All flags are levels from outside the clock domain and share one
    // synchroniser; the order of this concatenation is the bit order of the bus.
    pmsr_cond_if cond_bus ();
    pmsr_pkg::pmsr_cond_t raw_flags;

    assign raw_flags = {
        conv_current_limit_in,
        conv_undervoltage_in,
        conv_overvoltage_in,
        ext_monitor1_undervoltage_flag_in,
        ext_monitor1_overvoltage_flag_in,
        ext_monitor2_undervoltage_flag_in,
        ext_monitor2_overvoltage_flag_in,
        analog_supply_undervoltage_flag_in,
        analog_supply_overvoltage_flag_in,
        enable_pin_in,
        thermal_warning_flag_in,
        external_clock_invalid_flag_in
    };

    pmsr_sync #(
        .WIDTH(21)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .raw_in(raw_flags),
        .cond_port(cond_bus.source)
    );

    // ==================================================
    // Synchronised conditions, unpacked in capture order
    logic [3:0] ilim;
    logic [3:0] uv;
    logic [3:0] ov;
    logic mon1_uv;
    logic mon1_ov;
    logic mon2_uv;
    logic mon2_ov;
    logic sup_uv;
    logic sup_ov;
    logic en_lvl;
    logic twarn;
    logic clk_bad;

    assign {
        ilim,
        uv,
        ov,
        mon1_uv,
        mon1_ov,
        mon2_uv,
        mon2_ov,
        sup_uv,
        sup_ov,
        en_lvl,
        twarn,
        clk_bad
    } = cond_bus.cond;

    // ==================================================
    // Pair register packing, shared by both converter pairs
    function automatic logic [7:0] pack_pair(input pmsr_pkg::pmsr_conv_t hi,
                                             input pmsr_pkg::pmsr_conv_t lo);
        logic [7:0] v;
        v = `PMSR_RESET_VALUE;
        v[`PMSR_BIT_HI_ILIM] = hi.current_limit;
        v[`PMSR_BIT_HI_UV] = hi.undervoltage;
        v[`PMSR_BIT_HI_OV] = hi.overvoltage;
        v[`PMSR_BIT_LO_ILIM] = lo.current_limit;
        v[`PMSR_BIT_LO_UV] = lo.undervoltage;
        v[`PMSR_BIT_LO_OV] = lo.overvoltage;
        return v;
    endfunction

    function automatic pmsr_pkg::pmsr_conv_t conv(input int n);
        pmsr_pkg::pmsr_conv_t c;
        c.current_limit = ilim[n];
        c.undervoltage = uv[n];
        c.overvoltage = ov[n];
        return c;
    endfunction

    // ==================================================
    // Images of the single-register conditions
    function automatic logic [7:0] vmon_image(input logic m2_uv, input logic m2_ov,
                                              input logic m1_uv, input logic m1_ov,
                                              input logic s_uv, input logic s_ov);
        logic [7:0] v;
        v = `PMSR_RESET_VALUE;
        v[`PMSR_BIT_MON2_UV] = m2_uv;
        v[`PMSR_BIT_MON2_OV] = m2_ov;
        v[`PMSR_BIT_MON1_UV] = m1_uv;
        v[`PMSR_BIT_MON1_OV] = m1_ov;
        v[`PMSR_BIT_SUP_UV] = s_uv;
        v[`PMSR_BIT_SUP_OV] = s_ov;
        return v;
    endfunction

    function automatic logic [7:0] startup_image(input logic level);
        logic [7:0] v;
        v = `PMSR_RESET_VALUE;
        v[`PMSR_BIT_ENABLE] = level;
        return v;
    endfunction

    function automatic logic [7:0] misc_image(input logic warn, input logic clk_invalid);
        logic [7:0] v;
        v = `PMSR_RESET_VALUE;
        v[`PMSR_BIT_TWARN] = warn;
        v[`PMSR_BIT_EXTCLK] = clk_invalid;
        return v;
    endfunction

    // Offset decode; an unmapped offset reads zero and raises no hit
    function automatic logic offset_mapped(input logic [7:0] addr);
        case (addr)
            `PMSR_OFS_CONV12,
            `PMSR_OFS_CONV34,
            `PMSR_OFS_VMON,
            `PMSR_OFS_STARTUP,
            `PMSR_OFS_MISC: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction

    // ==================================================
    // Register state: live images, no latching of any condition
    typedef struct packed {
        logic [7:0] conv12;
        logic [7:0] conv34;
        logic [7:0] vmon;
        logic [7:0] startup;
        logic [7:0] misc;
        logic [7:0] rdata;
        logic hit;
    } pmsr_bank_state_t;

    pmsr_bank_state_t state;
    pmsr_bank_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.conv12 = pack_pair(conv(1), conv(0));
        next_state.conv34 = pack_pair(conv(3), conv(2));
        next_state.vmon = vmon_image(mon2_uv, mon2_ov, mon1_uv, mon1_ov, sup_uv, sup_ov);
        next_state.startup = startup_image(en_lvl);
        next_state.misc = misc_image(twarn, clk_bad);
        // Reads return the image current at the access; writes never alter it
        next_state.rdata = `PMSR_RESET_VALUE;
        next_state.hit = 1'h0;
        if (reg_read_in) begin
            next_state.hit = offset_mapped(reg_addr_in);
            case (reg_addr_in)
                `PMSR_OFS_CONV12: next_state.rdata = state.conv12;
                `PMSR_OFS_CONV34: next_state.rdata = state.conv34;
                `PMSR_OFS_VMON: next_state.rdata = state.vmon;
                `PMSR_OFS_STARTUP: next_state.rdata = state.startup;
                `PMSR_OFS_MISC: next_state.rdata = state.misc;
                default: next_state.rdata = `PMSR_RESET_VALUE;
            endcase
        end
        if (rst_in) begin
            next_state = '0;
        end
    end

    // A pin change reaches the image five edges later, four of them in the
    // synchroniser; software polling faster than that sees the older level.
    always_ff @(posedge core_clk_in) begin
        state <= next_state;
    end

    // ==================================================
    // Write port
    // Writes are taken and dropped: a stray write from the serial side can
    // never disturb an image, and no error is flagged for it.
    logic unused_write;
    assign unused_write = reg_write_in ^ (^reg_wdata_in);

    // ==================================================
    // Outputs come straight from flops
    assign reg_rdata_out = state.rdata;
    assign reg_hit_out = state.hit;
endmodule

// *** pmsr_tb_pkg.sv ***
// Expected register images for the status bank checks.
// Assumes flags packed as {clk, twarn, en, sup ov/uv, mon2 ov/uv, mon1 ov/uv, ov, uv, ilim}.
package pmsr_tb_pkg;
    function automatic logic pmsr_hit(input logic [7:0] a);
        return a inside {8'h6D, 8'h6E, 8'h72, 8'h73, 8'h74};
    endfunction
    function automatic logic [7:0] pmsr_img(input logic [20:0] v, input logic [7:0] a);
        case (a)
            8'h6D: return {v[1], 1'h0, v[5], v[9], v[0], 1'h0, v[4], v[8]};
            8'h6E: return {v[3], 1'h0, v[7], v[11], v[2], 1'h0, v[6], v[10]};
            8'h72: return {1'h0, v[14], v[15], 1'h0, v[12], v[13], v[16], v[17]};
            8'h73: return {6'h00, v[18], 1'h0};
            8'h74: return {4'h0, v[19], 1'h0, v[20], 1'h0};
            default: return 8'h00;
        endcase
    endfunction
endpackage

// *** pmsr_asserts.sv ***
// Port checks of the status bank.
// Assumes one clock; flags reach the image within about five edges.
module pmsr_asserts (
    input wire logic core_clk_in, rst_in, reg_read_in, reg_write_in, reg_hit_out,
    input wire logic [3:0] conv_current_limit_in, conv_undervoltage_in, conv_overvoltage_in,
    input wire logic ext_monitor1_undervoltage_flag_in, ext_monitor1_overvoltage_flag_in,
    input wire logic ext_monitor2_undervoltage_flag_in, ext_monitor2_overvoltage_flag_in,
    input wire logic analog_supply_undervoltage_flag_in, analog_supply_overvoltage_flag_in,
    input wire logic enable_pin_in, thermal_warning_flag_in, external_clock_invalid_flag_in,
    input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [20:0] flags, prev;
    logic [3:0] calm;
    logic [7:0] exp_q;
    assign flags = {external_clock_invalid_flag_in, thermal_warning_flag_in, enable_pin_in,
        analog_supply_overvoltage_flag_in, analog_supply_undervoltage_flag_in,
        ext_monitor2_overvoltage_flag_in, ext_monitor2_undervoltage_flag_in,
        ext_monitor1_overvoltage_flag_in, ext_monitor1_undervoltage_flag_in,
        conv_overvoltage_in, conv_undervoltage_in, conv_current_limit_in};
    // ==================================================
    // Quiet-flag counter: only settled flags give a checkable image
    always_ff @(posedge core_clk_in) begin
        prev <= flags;
        exp_q <= pmsr_tb_pkg::pmsr_img(flags, reg_addr_in);
        if (rst_in || flags != prev) begin
            calm <= 4'h0;
        end else if (calm != 4'hF) begin
            calm <= calm + 4'h1;
        end
    end
    // ==================================================
    // Properties
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd(a);
        reg_read_in && reg_addr_in == a;
    endsequence
    property p_rsv(a, m);
        s_rd(a) |=> (reg_rdata_out & m) == 8'h00;
    endproperty
    AST_IDLE: assert property (!reg_read_in
        |=> reg_rdata_out == 8'h00 && !reg_hit_out) else $error("output without read");
    AST_HIT: assert property (reg_read_in && pmsr_tb_pkg::pmsr_hit(reg_addr_in)
        |=> reg_hit_out) else $error("mapped read without hit");
    AST_UNMAP: assert property (reg_read_in && !pmsr_tb_pkg::pmsr_hit(reg_addr_in)
        |=> reg_rdata_out == 8'h00 && !reg_hit_out) else $error("unmapped read answered");
    AST_RST_ZERO: assert property ($fell(rst_in)
        |-> reg_rdata_out == 8'h00 && !reg_hit_out) else $error("outputs not cleared by reset");
    AST_RSV_CONV12: assert property (p_rsv(8'h6D, 8'h44))
        else $error("first pair reserved set");
    AST_RSV_PAIR: assert property (p_rsv(8'h6E, 8'h44))
        else $error("pair reserved set");
    AST_RSV_VMON: assert property (p_rsv(8'h72, 8'h90))
        else $error("monitor reserved set");
    AST_RSV_START: assert property (p_rsv(8'h73, 8'hFD))
        else $error("startup reserved set");
    AST_RSV_MISC: assert property (p_rsv(8'h74, 8'hF5))
        else $error("misc reserved set");
    AST_LIVE: assert property (reg_read_in && calm >= 4'h8
        |=> reg_rdata_out == exp_q) else $error("image differs from settled flags");
endmodule

// *** testbench.sv ***
// Self-checking bench: random flags, reads with concurrent writes, second reset.
// Assumes the design files and pmsr_tb_pkg.sv are compiled first.
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, rd, rd_d, wr, zexp, hit;
    logic [7:0] addr, wd, rdata;
    logic [20:0] v;
    logic [31:0] seed;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    int error_cnt, tests_run;
    logic [7:0] addrs[7] = '{8'h6D, 8'h6E, 8'h72, 8'h73, 8'h74, 8'h6F, 8'h00};
    pmsr_status_bank dut_u (.core_clk_in(clk), .rst_in(rst), .conv_current_limit_in(v[3:0]),
        .conv_undervoltage_in(v[7:4]), .conv_overvoltage_in(v[11:8]),
        .ext_monitor1_undervoltage_flag_in(v[12]), .ext_monitor1_overvoltage_flag_in(v[13]),
        .ext_monitor2_undervoltage_flag_in(v[14]), .ext_monitor2_overvoltage_flag_in(v[15]),
        .analog_supply_undervoltage_flag_in(v[16]), .analog_supply_overvoltage_flag_in(v[17]),
        .enable_pin_in(v[18]), .thermal_warning_flag_in(v[19]),
        .external_clock_invalid_flag_in(v[20]), .reg_read_in(rd), .reg_write_in(wr),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_hit_out(hit));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Each read carries a write to the same offset when seed bit 8 is set, with random data, which must change nothing
    task automatic read_reg(input logic [7:0] a);
        seed = lfsr(seed);
        rd = 1'h1;
        addr = a;
        wr = seed[8];
        wd = seed[7:0];
        exp_q.push_back({pmsr_tb_pkg::pmsr_hit(a), zexp ? 8'h00 : pmsr_tb_pkg::pmsr_img(v, a)});
        @(negedge clk);
    endtask
    task automatic sweep();
        foreach (addrs[i]) read_reg(addrs[i]);
        rd = 1'h0;
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) rd_d <= rd && !rst;
    always @(negedge clk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            `CHK("read", e, {hit, rdata})
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        seed = 32'h000125FF;
        rst = 1'h1;
        rd = 1'h0;
        wr = 1'h0;
        zexp = 1'h0;
        addr = 8'h00;
        wd = 8'h00;
        v = '0;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        sweep();
        repeat (40) begin
            seed = lfsr(seed);
            v = seed[20:0];
            repeat (10) @(negedge clk);
            sweep();
        end
        // Second reset with every flag raised: the image restarts from zero
        v = '1;
        rst = 1'h1;
        @(negedge clk);
        rst = 1'h0;
        zexp = 1'h1;
        read_reg(8'h6D);
        read_reg(8'h72);
        zexp = 1'h0;
        rd = 1'h0;
        repeat (10) @(negedge clk);
        sweep();
        repeat (2) @(negedge clk);
        wrap_up();
    end
endmodule
bind pmsr_status_bank pmsr_asserts chk_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .reg_read_in(reg_read_in), .reg_write_in(reg_write_in), .reg_hit_out(reg_hit_out),
    .conv_current_limit_in(conv_current_limit_in), .conv_undervoltage_in(conv_undervoltage_in),
    .conv_overvoltage_in(conv_overvoltage_in),
    .ext_monitor1_undervoltage_flag_in(ext_monitor1_undervoltage_flag_in),
    .ext_monitor1_overvoltage_flag_in(ext_monitor1_overvoltage_flag_in),
    .ext_monitor2_undervoltage_flag_in(ext_monitor2_undervoltage_flag_in),
    .ext_monitor2_overvoltage_flag_in(ext_monitor2_overvoltage_flag_in),
    .analog_supply_undervoltage_flag_in(analog_supply_undervoltage_flag_in),
    .analog_supply_overvoltage_flag_in(analog_supply_overvoltage_flag_in),
    .enable_pin_in(enable_pin_in), .thermal_warning_flag_in(thermal_warning_flag_in),
    .external_clock_invalid_flag_in(external_clock_invalid_flag_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out));
